// File: dap_audio_pwm.sv
`timescale 1ns/1ps
`default_nettype none
`include "dap_defs.svh"
module dap_audio_pwm (
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   input  wire logic              timer_on,
   input  wire logic [2:0]        counter_clock_select,
   input  wire logic              audio_pwm_select,
   input  wire logic [1:0]        operating_mode_field,
   input  wire logic [1:0]        output_control_field,
   input  wire logic              output_active_level,
   input  wire logic              output_polarity,
   input  wire logic              period_duty_swap,
   input  wire logic              clear_source_select,
   input  wire logic              period_wr,
   input  wire dap_pkg::dap_period_t period_register,
   input  wire logic              duty_one_wr,
   input  wire dap_pkg::dap_count_t duty_one_compare,
   input  wire logic              duty_two_wr,
   input  wire dap_pkg::dap_count_t duty_two_compare,
   input  wire logic              period_flag_clr,
   input  wire logic              duty_one_flag_clr,
   input  wire logic              duty_two_flag_clr,
   output logic                   pwm_out_one,
   output logic                   pwm_out_two,
   output logic                   period_match_flag,
   output logic                   duty_one_match_flag,
   output logic                   duty_two_match_flag,
   output logic                   period_duty_swap_eff
);
   import dap_pkg::*;

   typedef struct packed {
      dap_state_t  st;
      dap_count_t  cnt;
      dap_period_t per_sh;
      dap_period_t per_act;
      dap_count_t  d1_sh;
      dap_count_t  d1_act;
      dap_count_t  d2_sh;
      dap_count_t  d2_act;
      logic        pf;
      logic        af;
      logic        bf;
      logic        o1;
      logic        o2;
      logic        swap;
   } dap_core_t;

   dap_core_t s_q;
   dap_core_t s_d;
   dap_tick_if tk ();

   dap_clk_div u_div (
      .clk_sys              (clk_sys),
      .nrst                 (nrst),
      .run                  (s_q.st == DAP_RUN),
      .counter_clock_select (counter_clock_select),
      .tk                   (tk)
   );

   // pin level from raw waveform bit under the shared controls
   function automatic logic pin_level(input logic wave, input logic [1:0] oc,
                                      input logic act, input logic pol);
      logic w;
      w = wave ^ pol;
      unique case (oc)
         `DAP_OC_LOW:  pin_level = 1'b0;
         `DAP_OC_HIGH: pin_level = 1'b1;
         default:      pin_level = act ? w : ~w;
      endcase
   endfunction : pin_level

   // period match: counter equals four times period minus one; zero means full wrap
   function automatic logic per_hit(input dap_count_t c, input dap_period_t p);
      if (p == `DAP_RESET_BYTE) begin
         per_hit = (c == `DAP_CNT_MAX);
      end else begin
         per_hit = (c == ({p, 2'b00} - `DAP_CNT_STEP));
      end
   endfunction : per_hit

   logic audio;
   logic hit_p;
   logic hit_a;
   logic hit_b;
   logic w1;
   logic w2;

   // audio mode decode; clear source select deliberately unused here
   always_comb begin
      audio = (operating_mode_field == `DAP_MODE_PWM) && audio_pwm_select;
      hit_p = tk.tick && per_hit(s_q.cnt, s_q.per_act);
      hit_a = tk.tick && (s_q.cnt == s_q.d1_act);
      hit_b = tk.tick && (s_q.cnt == s_q.d2_act);
      w1    = (s_q.cnt < s_q.d1_act);
      w2    = (s_q.cnt < s_q.d2_act);
   end

   // one next-state block for the whole core
   always_comb begin
      s_d      = s_q;
      s_d.swap = audio ? 1'b0 : period_duty_swap;
      if (period_wr) s_d.per_sh = period_register;
      if (duty_one_wr) s_d.d1_sh = duty_one_compare;
      if (duty_two_wr) s_d.d2_sh = duty_two_compare;
      // set beats clear so an event in the clear cycle is kept
      if (period_flag_clr) s_d.pf = 1'b0;
      if (duty_one_flag_clr) s_d.af = 1'b0;
      if (duty_two_flag_clr) s_d.bf = 1'b0;
      unique case (s_q.st)
         DAP_IDLE: begin
            s_d.cnt     = `DAP_RESET_DUTY;
            s_d.per_act = s_d.per_sh;
            s_d.d1_act  = s_d.d1_sh;
            s_d.d2_act  = s_d.d2_sh;
            if (timer_on) s_d.st = DAP_RUN;
         end
         DAP_RUN: begin
            if (!timer_on) begin
               s_d.st = DAP_IDLE;
            end else if (tk.tick) begin
               s_d.cnt = s_q.cnt + `DAP_CNT_STEP;
               if (hit_p && audio) begin
                  s_d.cnt     = `DAP_RESET_DUTY;
                  s_d.per_act = s_d.per_sh;
                  s_d.d1_act  = s_d.d1_sh;
                  s_d.d2_act  = s_d.d2_sh;
               end
               if (hit_p) s_d.pf = 1'b1;
               if (hit_a) s_d.af = 1'b1;
               if (hit_b && audio) s_d.bf = 1'b1;
            end
         end
      endcase
      // waveform keeps running regardless of the pin control
      s_d.o1 = pin_level(w1 && s_q.st == DAP_RUN, output_control_field,
                         output_active_level, output_polarity);
      s_d.o2 = pin_level(w2 && s_q.st == DAP_RUN, output_control_field,
                         output_active_level, output_polarity);
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pwm_out_one          = s_q.o1;
   assign pwm_out_two          = s_q.o2;
   assign period_match_flag    = s_q.pf;
   assign duty_one_match_flag  = s_q.af;
   assign duty_two_match_flag  = s_q.bf;
   assign period_duty_swap_eff = s_q.swap;

   sequence s_run_tick;
      s_q.st == DAP_RUN && timer_on && tk.tick && audio;
   endsequence

   a_period_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_run_tick and hit_p |=> s_q.cnt == `DAP_RESET_DUTY && s_q.pf)
      else $error("period match did not clear counter");
   a_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_run_tick and hit_a |=> s_q.af)
      else $error("duty one flag missed");
   a_flag_two: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_run_tick and hit_b |=> s_q.bf)
      else $error("duty two flag missed");
   a_swap_forced: assert property (@(posedge clk_sys) disable iff (!nrst)
      audio |=> !period_duty_swap_eff)
      else $error("swap not forced to zero");
   a_shadow_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_q.st == DAP_RUN && timer_on && !hit_p |=> $stable(s_q.d1_act)
      && $stable(s_q.per_act))
      else $error("active compare changed mid period");
   a_idle_stop: assert property (@(posedge clk_sys) disable iff (!nrst)
      !timer_on |=> ##1 s_q.cnt == `DAP_RESET_DUTY)
      else $error("counter ran while timer off");
   a_force_low: assert property (@(posedge clk_sys) disable iff (!nrst)
      output_control_field == `DAP_OC_LOW |=> !pwm_out_one && !pwm_out_two)
      else $error("forced low not applied");
   a_wave_true: assert property (@(posedge clk_sys) disable iff (!nrst)
      output_control_field == `DAP_OC_PWM && output_active_level && !output_polarity
      && s_q.st == DAP_RUN |=> pwm_out_one == $past(w1))
      else $error("output one waveform wrong");
   // pin checks go through the shared controls, not just the raw compare
   a_zero_duty: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_q.st == DAP_RUN && s_q.d2_act == `DAP_RESET_DUTY
      && output_control_field == `DAP_OC_PWM && output_active_level && !output_polarity
      |=> !pwm_out_two)
      else $error("zero duty gave a pulse");
   a_force_high: assert property (@(posedge clk_sys) disable iff (!nrst)
      output_control_field == `DAP_OC_HIGH |=> pwm_out_one && pwm_out_two)
      else $error("forced high not applied");
   a_shadow_load: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_run_tick and hit_p |=> s_q.d1_act == s_q.d1_sh && s_q.d2_act == s_q.d2_sh
      && s_q.per_act == s_q.per_sh)
      else $error("shadow not loaded at period end");
   a_keep_run: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_run_tick and !hit_p and output_control_field == `DAP_OC_HIGH
      |=> s_q.cnt == $past(s_q.cnt) + `DAP_CNT_STEP)
      else $error("counter stalled under forced pin");
endmodule : dap_audio_pwm
`default_nettype wire

// File: dap_defs.svh
`ifndef DAP_DEFS_SVH
`define DAP_DEFS_SVH
// operating mode field codes
`define DAP_MODE_CMP     2'h0
`define DAP_MODE_PWM     2'h2
`define DAP_MODE_TMR     2'h3
// output control field codes
`define DAP_OC_LOW       2'h0
`define DAP_OC_HIGH      2'h1
`define DAP_OC_PWM       2'h2
`define DAP_OC_TOGGLE    2'h3
// counter clock select codes
`define DAP_CK_DIV4      3'h0
`define DAP_CK_SYS       3'h1
`define DAP_CK_HIGH      3'h5
`define DAP_DIV4_COUNT   2'h3
// counter and compare widths
`define DAP_CNT_W        10
`define DAP_CNT_MAX      10'h3ff
`define DAP_CNT_STEP     10'h001
`define DAP_PER_SHIFT    2
`define DAP_RESET_BYTE   8'h00
`define DAP_RESET_DUTY   10'h000
`endif

// File: dap_pkg.sv
package dap_pkg;
   typedef logic [9:0] dap_count_t;
   typedef logic [7:0] dap_period_t;
   // lifecycle of the counter
   typedef enum logic [0:0] {
      DAP_IDLE,
      DAP_RUN
   } dap_state_t;
endpackage : dap_pkg

// File: dap_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// counter clock enable handed from divider to the timer core
interface dap_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface : dap_tick_if
`default_nettype wire

// File: dap_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "dap_defs.svh"
module dap_clk_div (
   input  wire logic  clk_sys,
   input  wire logic  nrst,
   input  wire logic  run,
   input  wire logic [2:0] counter_clock_select,
   dap_tick_if.src    tk
);
   import dap_pkg::*;

   typedef struct packed {
      logic [1:0] pre;
      logic       tick;
   } dap_div_t;

   dap_div_t s_q;
   dap_div_t s_d;

   // full rate codes tick every cycle; everything else falls back to /4
   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (!run) begin
         s_d.pre = 2'h0;
      end else if (counter_clock_select == `DAP_CK_SYS ||
                   counter_clock_select == `DAP_CK_HIGH) begin
         // restart the prescaler so a later switch to /4 waits a full four cycles
         s_d.pre  = 2'h0;
         s_d.tick = 1'b1;
      end else begin
         s_d.pre  = s_q.pre + 2'h1;
         s_d.tick = (s_q.pre == `DAP_DIV4_COUNT);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tk.tick = s_q.tick;

   // a_div_spacing: in div4 mode ticks are four cycles apart
   a_div_spacing: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_q.tick && run && counter_clock_select == `DAP_CK_DIV4
      ##1 (run && counter_clock_select == `DAP_CK_DIV4) [*2]
      |=> !s_q.tick && !$past(s_q.tick) && !$past(s_q.tick, 2))
      else $error("div4 tick spacing wrong");
endmodule : dap_clk_div
`default_nettype wire

// File: dap_speaker.sv
`timescale 1ns/1ps
`default_nettype none
// speaker model: integrates each pin's high time over a listen window
module dap_speaker (
   input  wire logic        clk_sys,
   input  wire logic        pin_one,
   input  wire logic        pin_two,
   input  wire logic        listen,
   output var  logic        heard,
   output var  logic [10:0] cnt_one,
   output var  logic [10:0] cnt_two
);
   logic listen_q;
   // a one-period window makes the count independent of phase
   always_ff @(posedge clk_sys) begin
      listen_q <= listen;
      heard <= listen_q & ~listen;
      if (listen & ~listen_q) begin
         cnt_one <= 11'(pin_one);
         cnt_two <= 11'(pin_two);
      end else if (listen) begin
         cnt_one <= cnt_one + 11'(pin_one);
         cnt_two <= cnt_two + 11'(pin_two);
      end
   end
endmodule : dap_speaker
`default_nettype wire

// File: test_dual_output_audio_pwm.sv
`timescale 1ns/1ps
`default_nettype none
`include "dap_defs.svh"
module test_dual_output_audio_pwm;
   import dap_pkg::*;
   logic        clk_sys, nrst, timer_on, audio_pwm_select, output_active_level, heard;
   logic        output_polarity, period_duty_swap, clear_source_select, listen;
   logic        period_wr, duty_one_wr, duty_two_wr, period_flag_clr, duty_one_flag_clr;
   logic        duty_two_flag_clr, pwm_out_one, pwm_out_two, period_match_flag;
   logic        duty_one_match_flag, duty_two_match_flag, period_duty_swap_eff;
   logic [2:0]  counter_clock_select;
   logic [1:0]  operating_mode_field, output_control_field;
   logic [10:0] cnt_one, cnt_two;
   dap_period_t period_register;
   dap_count_t  duty_one_compare, duty_two_compare;
   logic [21:0] exp_q[$];
   logic [15:0] s;
   int          n_mismatch, samples_checked, cycles, ptick, fac;

   dap_audio_pwm i_dut (.clk_sys, .nrst, .timer_on, .counter_clock_select, .audio_pwm_select,
      .operating_mode_field, .output_control_field, .output_active_level, .output_polarity,
      .period_duty_swap, .clear_source_select, .period_wr, .period_register, .duty_one_wr,
      .duty_one_compare, .duty_two_wr, .duty_two_compare, .period_flag_clr,
      .duty_one_flag_clr, .duty_two_flag_clr, .pwm_out_one, .pwm_out_two,
      .period_match_flag, .duty_one_match_flag, .duty_two_match_flag, .period_duty_swap_eff);
   dap_speaker i_spk (.clk_sys, .pin_one(pwm_out_one), .pin_two(pwm_out_two), .listen,
      .heard, .cnt_one, .cnt_two);

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [21:0] seen, input logic [21:0] want);
      samples_checked++;
      if (seen !== want) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick

   // high clocks per period for a duty under the present pin setup
   function automatic logic [10:0] want(input dap_count_t d);
      int a;
      a = ((d > ptick) ? ptick : int'(d)) * fac;
      if (output_control_field == `DAP_OC_LOW) return 11'h000;
      if (output_control_field == `DAP_OC_HIGH) return 11'(ptick * fac);
      if (output_active_level ^ output_polarity) return 11'(a);
      return 11'(ptick * fac - a);
   endfunction : want

   task automatic hear(input int n, input logic [10:0] e1, input logic [10:0] e2);
      exp_q.push_back({e1, e2});
      listen <= 1'b1;
      tick(n);
      listen <= 1'b0;
      tick(3);
   endtask : hear

   // stopped timer loads its shadows at once, so setup happens while off
   task automatic setup(input logic [2:0] ck, input dap_period_t p);
      timer_on <= 1'b0;
      counter_clock_select <= ck;
      period_register <= p;
      period_wr <= 1'b1;
      clear_source_select <= 1'($urandom);
      tick(1);
      period_wr <= 1'b0;
      fac = (ck == `DAP_CK_SYS || ck == `DAP_CK_HIGH) ? 1 : 4;
      ptick = (p == 8'h00) ? 1024 : 4 * int'(p);
      tick(2);
      timer_on <= 1'b1;
   endtask : setup

   // new duties wait out two periods so the shadow has surely loaded
   task automatic play(input dap_count_t d1, input dap_count_t d2);
      duty_one_compare <= d1;
      duty_two_compare <= d2;
      {duty_one_wr, duty_two_wr, period_flag_clr, duty_one_flag_clr, duty_two_flag_clr} <= '1;
      tick(1);
      {duty_one_wr, duty_two_wr, period_flag_clr, duty_one_flag_clr, duty_two_flag_clr} <= '0;
      tick(2 * ptick * fac + 8);
      hear(ptick * fac, want(d1), want(d2));
   endtask : play

   // each closed window is matched to the oldest note
   always @(posedge clk_sys) begin
      if (heard === 1'b1) begin
         check({cnt_one, cnt_two}, exp_q.pop_front());
      end
   end

   // hang guard, well above the longest sequence
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         finish_test();
      end
   end

   initial begin
      {timer_on, listen, period_wr, duty_one_wr, duty_two_wr, output_polarity} = '0;
      {period_flag_clr, duty_one_flag_clr, duty_two_flag_clr, clear_source_select} = '0;
      {nrst, duty_one_compare, duty_two_compare} = '0;
      {audio_pwm_select, output_active_level, period_duty_swap} = '1;
      counter_clock_select = `DAP_CK_SYS;
      period_register = 8'h40;
      operating_mode_field = `DAP_MODE_PWM;
      output_control_field = `DAP_OC_PWM;
      void'($urandom(32'hb8fd_626b));
      tick(8);
      nrst <= 1'b1;
      // period loaded but timer left off: no match may appear
      period_wr <= 1'b1;
      tick(1);
      period_wr <= 1'b0;
      tick(300);
      check(period_match_flag, 1'b0);
      check(period_duty_swap_eff, 1'b0);
      for (int k = 0; k < 2; k++) begin
         setup(k ? `DAP_CK_HIGH : `DAP_CK_SYS, 8'h40);
         for (int i = 0; i < 4; i++) begin
            s = 16'($urandom);
            play(10'(s[15:8]), {2'b00, ~s[15:8]});
            play(s[15] ? 10'(s[14:7]) : 10'h000, s[15] ? 10'h000 : {2'b00, ~s[14:7]});
         end
      end
      setup(`DAP_CK_SYS, 8'h00);
      play(10'h200, 10'h3ff);
      setup(`DAP_CK_SYS, 8'h20);
      play(10'h000, 10'h07f);
      setup(`DAP_CK_DIV4, 8'h40);
      play(10'h040, 10'h0bf);
      setup(`DAP_CK_SYS, 8'h40);
      output_polarity <= 1'b1;
      play(10'h040, 10'h0bf);
      {output_polarity, output_active_level} <= 2'b00;
      play(10'h040, 10'h0bf);
      output_active_level <= 1'b1;
      // forced pins must not stop the counter or the compares
      for (int k = 3; k >= 0; k--) begin
         output_control_field <= 2'(k);
         play(10'h040, 10'h0bf);
         check({period_match_flag, duty_one_match_flag, duty_two_match_flag}, 3'h7);
      end
      output_control_field <= `DAP_OC_PWM;
      play(10'h000, 10'h0ff);
      period_flag_clr <= 1'b1;
      tick(1);
      period_flag_clr <= 1'b0;
      for (int i = 0; i < 300 && period_match_flag !== 1'b1; i++) tick(1);
      tick(8);
      // a write early in the period must not show before its end
      {duty_one_compare, duty_two_compare} <= {10'h0ff, 10'h000};
      {duty_one_wr, duty_two_wr} <= 2'b11;
      tick(1);
      {duty_one_wr, duty_two_wr} <= 2'b00;
      hear(128, 11'h000, 11'h080);
      audio_pwm_select <= 1'b0;
      tick(3);
      check(period_duty_swap_eff, 1'b1);
      finish_test();
   end
endmodule : test_dual_output_audio_pwm
`default_nettype wire
